/* hdl/rtc_time_alarm.sv */
`timescale 1ns/1ps
`include "rtc_regs.svh"

// Operation
// - Seconds count holds 0 to 59 in eight bits.
// - Time values read as binary or packed BCD per format select.
// - Seconds match compared with seconds count for the alarm.
// - Match value with both top bits set always matches.
// - Minutes match compared with minutes count for the alarm.
// - Minutes count holds 0 to 59 in eight bits.
// - In 12-hour mode hours bit 7 is the afternoon flag.
// - Hours low seven bits: 1..12 or 0..23 by hour mode.
// - Hours match compared with hours; software uses current formats.
// - Time advances once per second while running.
// - Alarm event raised when alarm equals current time in the cycle after an update.
// - Block reset returns all registers and logic to defaults.
module rtc_time_alarm #(
  parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Mode controls
  input wire logic run_in,
  input wire logic binary_format_select_in,
  input wire logic hour_mode_24_in,
  // Register port
  input wire rtc_pkg::rtc_req_t req_in,
  output logic [7:0] rdata_out,
  // Events
  output logic update_done_out,
  output logic alarm_event_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  rtc_pkg::rtc_time_t cnt_r, cnt_nxt;
  rtc_pkg::rtc_time_t match_r, match_nxt;
  logic [31:0] div_r, div_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic upd_r, upd_nxt;
  logic alarm_r, alarm_nxt;
  logic [7:0] sec_b, min_b, hr_b, sec_o, min_o, hr_o;
  logic [7:0] hr_lo, sec_n, min_n, hr_n;
  logic tick, sec_ok, min_ok, hr_ok;
  logic pm_n;

  // ****************************************************************
  // Format conversion
  // ****************************************************************
  // Internal counts kept in the software format; convert to binary
  assign hr_lo = {1'b0, cnt_r.hr[`RTC_HOUR_MSB:0]};
  rtc_bcd_conv u_sec_in (.to_bcd_in(1'b0), .value_in(cnt_r.sec),
    .value_out(sec_b));
  rtc_bcd_conv u_min_in (.to_bcd_in(1'b0), .value_in(cnt_r.min),
    .value_out(min_b));
  rtc_bcd_conv u_hr_in (.to_bcd_in(1'b0), .value_in(hr_lo),
    .value_out(hr_b));
  rtc_bcd_conv u_sec_out (.to_bcd_in(1'b1), .value_in(sec_n),
    .value_out(sec_o));
  rtc_bcd_conv u_min_out (.to_bcd_in(1'b1), .value_in(min_n),
    .value_out(min_o));
  rtc_bcd_conv u_hr_out (.to_bcd_in(1'b1), .value_in(hr_n),
    .value_out(hr_o));

  // ****************************************************************
  // Next time
  // ****************************************************************
  assign tick = run_in && (div_r == 32'(TICK_CYCLES - 1));

  always_comb begin
    sec_n = binary_format_select_in ? cnt_r.sec : sec_b;
    min_n = binary_format_select_in ? cnt_r.min : min_b;
    hr_n = binary_format_select_in ? hr_lo : hr_b;
    pm_n = cnt_r.hr[`RTC_HALF_DAY_BIT];
    if (sec_n >= `RTC_SEC_MAX) begin
      sec_n = `RTC_ZERO;
      if (min_n >= `RTC_MIN_MAX) begin
        min_n = `RTC_ZERO;
        if (hour_mode_24_in) begin
          hr_n = (hr_n >= `RTC_HR24_MAX) ? `RTC_ZERO : 8'(hr_n + 8'h01);
          pm_n = 1'b0;
        end else begin
          if (hr_n == `RTC_HR12_FLIP) begin
            pm_n = ~pm_n;
          end
          hr_n = (hr_n >= `RTC_HR12_MAX) ? `RTC_HR12_MIN
                                          : 8'(hr_n + 8'h01);
        end
      end else begin
        min_n = 8'(min_n + 8'h01);
      end
    end else begin
      sec_n = 8'(sec_n + 8'h01);
    end
  end

  // ****************************************************************
  // Alarm compare
  // ****************************************************************
  always_comb begin
    sec_ok = (match_r.sec[`RTC_DC_MSB:`RTC_DC_LSB] == `RTC_DONT_CARE) ||
             (match_r.sec == cnt_r.sec);
    min_ok = (match_r.min[`RTC_DC_MSB:`RTC_DC_LSB] == `RTC_DONT_CARE) ||
             (match_r.min == cnt_r.min);
    hr_ok = (match_r.hr[`RTC_DC_MSB:`RTC_DC_LSB] == `RTC_DONT_CARE) ||
            (match_r.hr == cnt_r.hr);
  end

  // ****************************************************************
  // One-second divider
  // ****************************************************************
  always_comb begin
    div_nxt = div_r;
    if (run_in) begin
      div_nxt = tick ? `RTC_DIV_ZERO : 32'(div_r + 32'h1);
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_r <= `RTC_DIV_ZERO;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ****************************************************************
  // Update and alarm events
  // ****************************************************************
  always_comb begin
    upd_nxt = tick;
    alarm_nxt = 1'b0;
    // Alarm evaluated one cycle after each update
    if (upd_r) begin
      alarm_nxt = sec_ok && min_ok && hr_ok;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      upd_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      upd_r <= upd_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  // ****************************************************************
  // Time and match registers
  // ****************************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    match_nxt = match_r;
    if (tick) begin
      cnt_nxt.sec = binary_format_select_in ? sec_n : sec_o;
      cnt_nxt.min = binary_format_select_in ? min_n : min_o;
      cnt_nxt.hr = {pm_n && !hour_mode_24_in,
        (binary_format_select_in ? hr_n[`RTC_HOUR_MSB:0]
                                 : hr_o[`RTC_HOUR_MSB:0])};
    end
    // Software write wins over the hardware update
    if (req_in.wr) begin
      unique case (req_in.addr)
        `RTC_OFS_SEC_COUNT: cnt_nxt.sec = req_in.wdata;
        `RTC_OFS_SEC_MATCH: match_nxt.sec = req_in.wdata;
        `RTC_OFS_MIN_COUNT: cnt_nxt.min = req_in.wdata;
        `RTC_OFS_MIN_MATCH: match_nxt.min = req_in.wdata;
        `RTC_OFS_HR_COUNT: cnt_nxt.hr = req_in.wdata;
        `RTC_OFS_HR_MATCH: match_nxt.hr = req_in.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r.sec <= `RTC_RST_VAL;
      cnt_r.min <= `RTC_RST_VAL;
      cnt_r.hr <= `RTC_RST_VAL;
      match_r.sec <= `RTC_RST_VAL;
      match_r.min <= `RTC_RST_VAL;
      match_r.hr <= `RTC_RST_VAL;
    end else begin
      cnt_r <= cnt_nxt;
      match_r <= match_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_nxt = rdata_r;
    // Read together with a write returns the old value
    if (req_in.rd) begin
      unique case (req_in.addr)
        `RTC_OFS_SEC_COUNT: rdata_nxt = cnt_r.sec;
        `RTC_OFS_SEC_MATCH: rdata_nxt = match_r.sec;
        `RTC_OFS_MIN_COUNT: rdata_nxt = cnt_r.min;
        `RTC_OFS_MIN_MATCH: rdata_nxt = match_r.min;
        `RTC_OFS_HR_COUNT: rdata_nxt = cnt_r.hr;
        `RTC_OFS_HR_MATCH: rdata_nxt = match_r.hr;
        default: rdata_nxt = `RTC_RST_VAL;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= `RTC_RST_VAL;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_out = rdata_r;
  assign update_done_out = upd_r;
  assign alarm_event_out = alarm_r;

endmodule

/* shared/rtc_regs.svh */
`ifndef RTC_TIME_REGS_SVH
`define RTC_TIME_REGS_SVH

// ******************************************************************
// Register offsets
// ******************************************************************
`define RTC_OFS_SEC_COUNT 8'h00
`define RTC_OFS_SEC_MATCH 8'h01
`define RTC_OFS_MIN_COUNT 8'h02
`define RTC_OFS_MIN_MATCH 8'h03
`define RTC_OFS_HR_COUNT 8'h04
`define RTC_OFS_HR_MATCH 8'h05

// ******************************************************************
// Reset values and fields
// ******************************************************************
`define RTC_RST_VAL 8'h00
`define RTC_DONT_CARE 2'h3
`define RTC_HALF_DAY_BIT 7
`define RTC_HOUR_MSB 6
`define RTC_DC_MSB 7
`define RTC_DC_LSB 6
`define RTC_DIV_ZERO 32'h0000_0000

// ******************************************************************
// Limits in binary
// ******************************************************************
`define RTC_SEC_MAX 8'h3B
`define RTC_MIN_MAX 8'h3B
`define RTC_HR24_MAX 8'h17
`define RTC_HR12_MAX 8'h0C
`define RTC_HR12_MIN 8'h01
`define RTC_HR12_FLIP 8'h0B
`define RTC_ZERO 8'h00

// ******************************************************************
// Timing
// ******************************************************************
`define RTC_CLK_HZ 32768
`define RTC_TICK_SEC 1
`define RTC_TICK_CYCLES (`RTC_CLK_HZ * `RTC_TICK_SEC)

`endif

/* shared/rtc_pkg.sv */
package rtc_pkg;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtc_req_t;

  // Time set
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
  } rtc_time_t;

endpackage

/* hdl/rtc_bcd_conv.sv */
`timescale 1ns/1ps
`include "rtc_regs.svh"

// Converts between binary and packed BCD for values 0..99
module rtc_bcd_conv (
  // Selection
  input wire logic to_bcd_in,
  // Data
  input wire logic [7:0] value_in,
  output logic [7:0] value_out
);
  logic [7:0] tens;
  logic [7:0] prod;

  always_comb begin
    tens = 8'h00;
    prod = 8'h00;
    if (to_bcd_in) begin
      tens = value_in / 8'h0A;
      prod = 8'(tens * 8'h0A);
      value_out = {tens[3:0], 4'(value_in - prod)};
    end else begin
      prod = 8'({4'h0, value_in[7:4]} * 8'h0A);
      value_out = 8'(prod + {4'h0, value_in[3:0]});
    end
  end
endmodule

/* verif/rtc_host_model.sv */
`timescale 1ns/1ps
// *****************
// Host register port
// *****************
module rtc_host_model (
  // Clock and read data
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  // Requests
  output rtc_pkg::rtc_req_t req_out
);
  initial req_out = '0;
  // Caller encodes data in the current formats
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req_out <= '{1'b1, 1'b0, a, d};
    @(posedge clock_in);
    req_out <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    req_out <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_in);
    req_out <= '0;
    @(negedge clock_in);
    d = rdata_in;
  endtask
endmodule

/* verif/rtc_time_alarm_assertions.sv */
`timescale 1ns/1ps
module rtc_time_alarm_assertions (
  // Clock, reset and controls
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  input wire logic binary_format_select_in,
  input wire logic hour_mode_24_in,
  // Register port and events
  input wire rtc_pkg::rtc_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire logic update_done_out,
  input wire logic alarm_event_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  property p_rst; $rose(reset_n_in) |-> rdata_out == 8'h00 &&
    !update_done_out && !alarm_event_out; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_run; !$past(run_in) |-> !update_done_out; endproperty
  a_run: assert property (p_run) else $error("update stopped");
  property p_gap; update_done_out |=> !update_done_out [*3]; endproperty
  a_gap: assert property (p_gap) else $error("update spacing");
  property p_alm; alarm_event_out |-> $past(update_done_out); endproperty
  a_alm: assert property (p_alm) else $error("alarm timing");
  property p_one; alarm_event_out |=> !alarm_event_out; endproperty
  a_one: assert property (p_one) else $error("alarm length");
  property p_rw; req_in.wr && req_in.addr == 8'h01 ##1 !req_in.wr ##1
    req_in.rd && req_in.addr == 8'h01 |=>
    rdata_out == $past(req_in.wdata, 3); endproperty
  a_rw: assert property (p_rw) else $error("match readback");
  property p_sm; binary_format_select_in && req_in.rd &&
    req_in.addr inside {8'h00, 8'h02} |=> rdata_out <= 8'h3B; endproperty
  a_sm: assert property (p_sm) else $error("sec min range");
  property p_hr; binary_format_select_in && hour_mode_24_in && req_in.rd
    && req_in.addr == 8'h04 |=> rdata_out <= 8'h17; endproperty
  a_hr: assert property (p_hr) else $error("hour range");
endmodule
bind rtc_time_alarm rtc_time_alarm_assertions u_chk (.clock_in(clock_in),
  .reset_n_in(reset_n_in), .run_in(run_in),
  .binary_format_select_in(binary_format_select_in),
  .hour_mode_24_in(hour_mode_24_in), .req_in(req_in),
  .rdata_out(rdata_out), .update_done_out(update_done_out),
  .alarm_event_out(alarm_event_out));

/* verif/rtc_time_and_alarm_regs_bench.sv */
`timescale 1ns/1ps
module rtc_time_and_alarm_regs_bench;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, fmt = 1'b1, h24 = 1'b1;
  rtc_pkg::rtc_req_t req;
  logic [7:0] rdat, v, s;
  logic upd, alm, a;
  int mismatches = 0, n_checks = 0, cyc = 0;
  integer seed = 32'hD27FDA68;
  localparam logic [24:0] AT [5] = '{25'h100C0FF, 25'h001C0C0,
    25'h00001C0, 25'h0C0C001, 25'h1000000};
  localparam logic [15:0] HT [3] = '{16'h1192, 16'h9281, 16'h0910};
  initial forever #20 clk = ~clk;
  rtc_host_model host (.clock_in(clk), .rdata_in(rdat), .req_out(req));
  rtc_time_alarm #(.TICK_CYCLES(4)) dut (.clock_in(clk), .reset_n_in(rst_n),
    .run_in(run), .binary_format_select_in(fmt), .hour_mode_24_in(h24),
    .req_in(req), .rdata_out(rdat), .update_done_out(upd),
    .alarm_event_out(alm));
  function automatic logic [7:0] nxt(logic [7:0] x, logic [7:0] m, logic b);
    if (x == m) return 8'h00;
    if (b || x[3:0] != 4'h9) return x + 8'h01;
    return {x[7:4] + 4'h1, 4'h0};
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(logic [7:0] ad, logic [7:0] e);
    host.rd(ad, v);
    chk("register", e, v);
  endtask
  task automatic tick(output logic al);
    int i;
    i = 0;
    @(posedge clk) run <= 1'b1;
    while (upd !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    chk("update", 8'h01, {7'h00, upd});
    @(posedge clk) run <= 1'b0;
    @(negedge clk) al = alm;
  endtask
  task automatic do_reset();
    @(posedge clk) rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // *****************
  // Test sequence
  // *****************
  initial begin
    do_reset();
    for (int k = 0; k < 7; k++) rchk(k[7:0], 8'h00);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      s = 8'(($random(seed) & 32'h3F) % 32'h3C);
      host.wr(8'h00, s);
      tick(a);
      rchk(8'h00, nxt(s, 8'h3B, 1'b1));
    end
    $display("test seconds done");
    for (int k = 0; k < 5; k++) begin
      host.wr(8'h00, 8'h3B);
      host.wr(8'h02, 8'h3B);
      host.wr(8'h04, 8'h17);
      host.wr(8'h03, AT[k][15:8]);
      host.wr(8'h05, AT[k][7:0]);
      host.wr(8'h01, AT[k][23:16]);
      rchk(8'h01, AT[k][23:16]);
      tick(a);
      chk("alarm", {7'h00, AT[k][24]}, {7'h00, a});
    end
    for (int k = 0; k < 3; k++) rchk(8'(2 * k), 8'h00);
    $display("test alarm done");
    host.wr(8'h00, 8'h2A);
    host.wr(8'h05, 8'hC3);
    @(posedge clk);
    fmt <= 1'b0;
    h24 <= 1'b0;
    do_reset();
    for (int k = 0; k < 6; k++) rchk(k[7:0], 8'h00);
    for (int k = 0; k < 3; k++) begin
      host.wr(8'h00, 8'h59);
      host.wr(8'h02, 8'h59);
      host.wr(8'h04, HT[k][15:8]);
      tick(a);
      rchk(8'h04, HT[k][7:0]);
    end
    host.wr(8'h00, 8'h29);
    tick(a);
    rchk(8'h00, nxt(8'h29, 8'h59, 1'b0));
    $display("test bcd done");
    tally_and_finish();
  end
endmodule
